/* File: logic/i2cs_params.svh */
// i2cs_params.svh: offsets, field positions, reset values and timing for the two-wire start/stop control
// assumes a 32-bit classic wishbone slave, registers one per aligned word, and a 50 MHz system clock
`ifndef I2CS_PARAMS_SVH
`define I2CS_PARAMS_SVH

// register byte addresses
`define I2CS_ADR_CTRL 5'h00
`define I2CS_ADR_STAT 5'h04
`define I2CS_ADR_IRQS 5'h08
`define I2CS_ADR_IRQM 5'h0C
`define I2CS_ADR_HSEL 5'h10

// control register fields
`define I2CS_B_RATE2 7
`define I2CS_B_EN 6
`define I2CS_B_STA 5
`define I2CS_B_STO 4
`define I2CS_B_SI 3
`define I2CS_B_AA 2
`define I2CS_CTRL_RST 8'h00

// host port select value that lets the interface run
`define I2CS_HSEL_ON 2'h2
`define I2CS_HSEL_RST 2'h0

// status codes
`define I2CS_ST_START 8'h08
`define I2CS_ST_RSTART 8'h10
`define I2CS_ST_IDLE 8'hF8

// irq bit positions
`define I2CS_IRQ_START 0
`define I2CS_IRQ_RSTART 1
`define I2CS_IRQ_STOP 2

// half of each system clock division factor, per rate select code
`define I2CS_HALF_0 8'h05
`define I2CS_HALF_1 8'h0A
`define I2CS_HALF_2 8'h0F
`define I2CS_HALF_3 8'h14
`define I2CS_HALF_4 8'h28
`define I2CS_HALF_5 8'h3C
`define I2CS_HALF_6 8'h50
`define I2CS_HALF_7 8'h78

`endif

/* File: logic/i2cs_pkg.sv */
// i2cs_pkg: types shared by the two-wire start/stop control files
// assumes i2cs_params.svh carries all numeric constants
package i2cs_pkg;

  typedef enum logic [3:0] {
    I2CS_IDLE,
    I2CS_WAIT_FREE,
    I2CS_FREE_DLY,
    I2CS_START_HOLD,
    I2CS_MASTER,
    I2CS_RS_SDAH,
    I2CS_RS_SCLH,
    I2CS_STOP_LOW,
    I2CS_STOP_SCLH,
    I2CS_STOP_DONE
  } i2cs_state_t;

  // one-cycle events raised by the sequencer
  typedef struct packed {
    logic stop_seen;
    logic rstart_sent;
    logic start_sent;
  } i2cs_evt_t;

  // drive state of the two open-drain pins
  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } i2cs_drv_t;

endpackage

/* File: logic/i2cs_rate_gen.sv */
// i2cs_rate_gen: half-period tick generator for the serial clock
// assumes the rate select code is stable while run is high
`timescale 1ns/10ps
`include "i2cs_params.svh"

module i2cs_rate_gen
  import i2cs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic [2:0] rate_sel,
  output logic half_tick
);

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic tick_nxt;

  // half of the division factor for a rate code
  function automatic logic [7:0] half_count(input logic [2:0] sel);
    case (sel)
      3'h0: half_count = `I2CS_HALF_0;
      3'h1: half_count = `I2CS_HALF_1;
      3'h2: half_count = `I2CS_HALF_2;
      3'h3: half_count = `I2CS_HALF_3;
      3'h4: half_count = `I2CS_HALF_4;
      3'h5: half_count = `I2CS_HALF_5;
      3'h6: half_count = `I2CS_HALF_6;
      default: half_count = `I2CS_HALF_7;
    endcase
  endfunction

  // counter held at zero while idle, so each timed step gets a full half period
  always_comb
  begin
    cnt_nxt = 8'h00;
    tick_nxt = 1'b0;
    if (run)
    begin
      if (cnt_r == half_count(rate_sel) - 8'h01)
      begin
        tick_nxt = 1'b1;
      end
      else
      begin
        cnt_nxt = cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_r <= 8'h00;
      half_tick <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      half_tick <= tick_nxt;
    end
  end

endmodule // i2cs_rate_gen

/* File: logic/i2cs_ctrl.sv */
// i2cs_ctrl: control register, start/stop sequencer and bus watcher of the two-wire master
// assumes open-drain pins resolved outside, an external byte engine and slave address matcher on clk
`timescale 1ns/10ps
`include "i2cs_params.svh"

module i2cs_ctrl
  import i2cs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic byte_done_i,
  input wire logic addr_match_i,
  output logic master_o,
  output logic slave_addressed_o
);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  logic [7:0] ctrl_r, ctrl_nxt;
  logic [7:0] stat_r, stat_nxt;
  logic [2:0] irqs_r, irqs_nxt;
  logic [2:0] irqm_r, irqm_nxt;
  logic [1:0] hsel_r, hsel_nxt;
  logic [31:0] rdat_nxt;
  logic ack_nxt, irq_nxt;
  logic [2:0] scl_sy_r, scl_sy_nxt, sda_sy_r, sda_sy_nxt;
  logic scl_f_r, scl_f_nxt, sda_f_r, sda_f_nxt, sda_fp_r;
  logic busy_r, busy_nxt;
  i2cs_state_t state_r, state_nxt;
  logic master_nxt, bytes_r, bytes_nxt, slv_nxt;
  i2cs_drv_t drv_nxt;
  i2cs_evt_t evt;
  logic sto_clr, int_stop, half_tick, run;
  logic active, start_det, stop_det, acc, wr;

  // enabled only with the right host select value
  assign active = ctrl_r[`I2CS_B_EN] && (hsel_r == `I2CS_HSEL_ON);
  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = acc && wb_we_i && wb_sel_i[0];
  assign start_det = active && scl_f_r && sda_fp_r && !sda_f_r;
  assign stop_det = active && scl_f_r && !sda_fp_r && sda_f_r;

  // pin sampling: a level counts once the second and third stages agree
  always_comb
  begin
    scl_sy_nxt = {scl_sy_r[1:0], scl_i};
    sda_sy_nxt = {sda_sy_r[1:0], sda_i};
    scl_f_nxt = (scl_sy_r[1] == scl_sy_r[2]) ? scl_sy_r[2] : scl_f_r;
    sda_f_nxt = (sda_sy_r[1] == sda_sy_r[2]) ? sda_sy_r[2] : sda_f_r;
    busy_nxt = busy_r;
    if (!active)
    begin
      busy_nxt = 1'b0;
    end
    else if (start_det)
    begin
      busy_nxt = 1'b1;
    end
    else if (stop_det || int_stop)
    begin
      busy_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_sy_r <= 3'h7;
      sda_sy_r <= 3'h7;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
      sda_fp_r <= 1'b1;
      busy_r <= 1'b0;
    end
    else
    begin
      scl_sy_r <= scl_sy_nxt;
      sda_sy_r <= sda_sy_nxt;
      scl_f_r <= scl_f_nxt;
      sda_f_r <= sda_f_nxt;
      sda_fp_r <= sda_f_r;
      busy_r <= busy_nxt;
    end
  end

  // divided serial clock times every half-period step
  assign run = active && (state_r != I2CS_IDLE) && (state_r != I2CS_WAIT_FREE) && (state_r != I2CS_MASTER)
               && (state_r != I2CS_STOP_DONE);

  i2cs_rate_gen u_rate
  (
    .clk(clk),
    .reset_n(reset_n),
    .run(run),
    .rate_sel({ctrl_r[`I2CS_B_RATE2], ctrl_r[1:0]}),
    .half_tick(half_tick)
  );

  // sequencer; in the idle and master states a stop request goes ahead of a start request
  always_comb
  begin
    state_nxt = state_r;
    master_nxt = master_o;
    bytes_nxt = bytes_r;
    slv_nxt = slave_addressed_o;
    sto_clr = 1'b0;
    int_stop = 1'b0;
    evt = '0;
    if (!active)
    begin
      state_nxt = I2CS_IDLE;
      master_nxt = 1'b0;
      bytes_nxt = 1'b0;
      slv_nxt = 1'b0;
    end
    else
    begin
      if (addr_match_i && state_r == I2CS_IDLE)
      begin
        slv_nxt = 1'b1;
      end
      if (byte_done_i && state_r == I2CS_MASTER)
      begin
        bytes_nxt = 1'b1;
      end
      case (state_r)
        I2CS_IDLE:
        begin
          if (ctrl_r[`I2CS_B_STO])
          begin
            int_stop = 1'b1;
            sto_clr = 1'b1;
            slv_nxt = 1'b0;
            evt.stop_seen = 1'b1;
          end
          else if (ctrl_r[`I2CS_B_STA])
          begin
            state_nxt = busy_r ? I2CS_WAIT_FREE : I2CS_START_HOLD;
          end
        end
        I2CS_WAIT_FREE:
        begin
          if (!ctrl_r[`I2CS_B_STA])
          begin
            state_nxt = I2CS_IDLE;
          end
          else if (stop_det)
          begin
            state_nxt = I2CS_FREE_DLY;
          end
        end
        I2CS_FREE_DLY:
        begin
          // a request withdrawn during the delay must not still put a start on the bus
          if (!ctrl_r[`I2CS_B_STA])
          begin
            state_nxt = I2CS_IDLE;
          end
          else if (half_tick)
          begin
            state_nxt = I2CS_START_HOLD;
          end
        end
        I2CS_START_HOLD:
        begin
          if (half_tick)
          begin
            state_nxt = I2CS_MASTER;
            master_nxt = 1'b1;
            bytes_nxt = 1'b0;
            slv_nxt = 1'b0;
            evt.rstart_sent = master_o;
            evt.start_sent = !master_o;
          end
        end
        I2CS_MASTER:
        begin
          if (ctrl_r[`I2CS_B_STO])
          begin
            state_nxt = I2CS_STOP_LOW;
          end
          else if (ctrl_r[`I2CS_B_STA] && bytes_r)
          begin
            state_nxt = I2CS_RS_SDAH;
          end
        end
        I2CS_RS_SDAH:
        begin
          if (half_tick)
          begin
            state_nxt = I2CS_RS_SCLH;
          end
        end
        I2CS_RS_SCLH:
        begin
          if (half_tick)
          begin
            state_nxt = I2CS_START_HOLD;
          end
        end
        I2CS_STOP_LOW:
        begin
          if (half_tick)
          begin
            state_nxt = I2CS_STOP_SCLH;
          end
        end
        I2CS_STOP_SCLH:
        begin
          if (half_tick)
          begin
            state_nxt = I2CS_STOP_DONE;
          end
        end
        I2CS_STOP_DONE:
        begin
          if (stop_det)
          begin
            state_nxt = I2CS_IDLE;
            sto_clr = 1'b1;
            master_nxt = 1'b0;
            evt.stop_seen = 1'b1;
          end
        end
        default: state_nxt = I2CS_IDLE;
      endcase
    end
    // pins only ever pulled low; released (high) otherwise
    drv_nxt.scl_oe = (state_nxt == I2CS_MASTER) || (state_nxt == I2CS_RS_SDAH) || (state_nxt == I2CS_STOP_LOW);
    drv_nxt.sda_oe = (state_nxt == I2CS_START_HOLD) || (state_nxt == I2CS_MASTER) || (state_nxt == I2CS_STOP_LOW)
                     || (state_nxt == I2CS_STOP_SCLH);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= I2CS_IDLE;
      master_o <= 1'b0;
      bytes_r <= 1'b0;
      slave_addressed_o <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      master_o <= master_nxt;
      bytes_r <= bytes_nxt;
      slave_addressed_o <= slv_nxt;
      scl_oe <= drv_nxt.scl_oe;
      sda_oe <= drv_nxt.sda_oe;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  // register file; hardware sets win over software clears
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    stat_nxt = stat_r;
    irqm_nxt = irqm_r;
    hsel_nxt = hsel_r;
    irqs_nxt = irqs_r | evt;
    if (sto_clr)
    begin
      ctrl_nxt[`I2CS_B_STO] = 1'b0;
    end
    if (wr)
    begin
      case (wb_adr_i)
        `I2CS_ADR_CTRL: ctrl_nxt = wb_dat_i[7:0];
        `I2CS_ADR_IRQS: irqs_nxt = (irqs_r & ~wb_dat_i[2:0]) | evt;
        `I2CS_ADR_IRQM: irqm_nxt = wb_dat_i[2:0];
        `I2CS_ADR_HSEL: hsel_nxt = wb_dat_i[1:0];
        default: ;
      endcase
    end
    if (!ctrl_nxt[`I2CS_B_EN])
    begin
      ctrl_nxt[`I2CS_B_STO] = 1'b0;
    end
    if (evt.start_sent)
    begin
      stat_nxt = `I2CS_ST_START;
    end
    else if (evt.rstart_sent)
    begin
      stat_nxt = `I2CS_ST_RSTART;
    end
    else if (evt.stop_seen || !active)
    begin
      stat_nxt = `I2CS_ST_IDLE;
    end
    if (evt.start_sent || evt.rstart_sent)
    begin
      ctrl_nxt[`I2CS_B_SI] = 1'b1;
    end
    rdat_nxt = 32'h0000_0000;
    if (acc && !wb_we_i)
    begin
      case (wb_adr_i)
        `I2CS_ADR_CTRL: rdat_nxt = {24'h00_0000, ctrl_r};
        `I2CS_ADR_STAT: rdat_nxt = {24'h00_0000, stat_r};
        `I2CS_ADR_IRQS: rdat_nxt = {29'h0000_0000, irqs_r};
        `I2CS_ADR_IRQM: rdat_nxt = {29'h0000_0000, irqm_r};
        `I2CS_ADR_HSEL: rdat_nxt = {30'h0000_0000, hsel_r};
        default: rdat_nxt = 32'h0000_0000;
      endcase
    end
    ack_nxt = acc;
    irq_nxt = |(irqs_nxt & irqm_nxt);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_r <= `I2CS_CTRL_RST;
      stat_r <= `I2CS_ST_IDLE;
      irqs_r <= 3'h0;
      irqm_r <= 3'h0;
      hsel_r <= `I2CS_HSEL_RST;
      wb_dat_o <= 32'h0000_0000;
      wb_ack_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      stat_r <= stat_nxt;
      irqs_r <= irqs_nxt;
      irqm_r <= irqm_nxt;
      hsel_r <= hsel_nxt;
      wb_dat_o <= rdat_nxt;
      wb_ack_o <= ack_nxt;
      irq_o <= irq_nxt;
    end
  end

  // checks
  sequence s_stop_bus;
    (state_r == I2CS_STOP_DONE) && stop_det;
  endsequence
  sequence s_free_wait;
    (state_r == I2CS_WAIT_FREE) && stop_det && ctrl_r[`I2CS_B_STA] && active;
  endsequence

  a_disable_pins: assert property (!active |=> !scl_oe && !sda_oe && !slave_addressed_o)
    else $error("pins driven while disabled");
  a_sto_forced: assert property (!ctrl_r[`I2CS_B_EN] |-> !ctrl_r[`I2CS_B_STO])
    else $error("stop request set while disabled");
  a_disable_keeps: assert property ($fell(ctrl_r[`I2CS_B_EN]) |->
    (ctrl_r[7] == $past(wb_dat_i[7])) && (ctrl_r[5] == $past(wb_dat_i[5]))
    && (ctrl_r[2:0] == $past(wb_dat_i[2:0])))
    else $error("other bits changed on disable");
  a_hsel_gate: assert property ((hsel_r != `I2CS_HSEL_ON) |=> state_r == I2CS_IDLE)
    else $error("active with wrong host select");
  a_start_free: assert property ((state_r == I2CS_IDLE) && active && ctrl_r[`I2CS_B_STA]
    && !ctrl_r[`I2CS_B_STO] && !busy_r |=> (state_r == I2CS_START_HOLD) ##1 sda_oe && !scl_oe)
    else $error("start not issued on free bus");
  a_defer_start: assert property (s_free_wait |=> (state_r == I2CS_FREE_DLY) ##[1:121]
    (state_r == I2CS_START_HOLD || !active || !ctrl_r[`I2CS_B_STA]))
    else $error("deferred start not after half period");
  a_rep_start: assert property ((state_r == I2CS_MASTER) && active && ctrl_r[`I2CS_B_STA]
    && !ctrl_r[`I2CS_B_STO] && bytes_r |=> state_r == I2CS_RS_SDAH)
    else $error("repeated start missing");
  a_no_start: assert property ($rose(state_r == I2CS_START_HOLD) |-> $past(ctrl_r[`I2CS_B_STA]))
    else $error("start without request");
  a_stop_clear: assert property (s_stop_bus |=> !ctrl_r[`I2CS_B_STO] && !master_o ##0 irqs_r[`I2CS_IRQ_STOP])
    else $error("stop request not cleared");
  a_slave_stop: assert property ((state_r == I2CS_IDLE) && active && ctrl_r[`I2CS_B_STO]
    |=> !slave_addressed_o && !ctrl_r[`I2CS_B_STO] && !sda_oe && !scl_oe)
    else $error("slave stop recovery wrong");
  a_no_stop: assert property ($rose(state_r == I2CS_STOP_LOW) |-> $past(ctrl_r[`I2CS_B_STO]))
    else $error("stop without request");
  a_start_code: assert property ((state_r == I2CS_START_HOLD) && half_tick && !master_o |=>
    (stat_r == `I2CS_ST_START) && ctrl_r[`I2CS_B_SI] && irqs_r[`I2CS_IRQ_START])
    else $error("start status wrong");
  a_rstart_code: assert property ((state_r == I2CS_START_HOLD) && half_tick && master_o |=>
    (stat_r == `I2CS_ST_RSTART) && irqs_r[`I2CS_IRQ_RSTART])
    else $error("repeated start status wrong");

endmodule // i2cs_ctrl

/* File: verif/i2cs_bus_peer.sv */
// i2cs_bus_peer: behavioural peripheral on the two-wire bus, able to occupy the bus like another master
// assumes open-drain wires with pull-ups resolved in the bench; pull outputs high mean pulling low
`timescale 1ns/10ps

module i2cs_bus_peer (
  input wire logic scl,
  input wire logic sda,
  input wire logic busy_req,
  output logic scl_pull,
  output logic sda_pull,
  output int start_cnt,
  output int stop_cnt
);
  initial
  begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    start_cnt = 0;
    stop_cnt = 0;
  end

  // foreign frame at a 160 ns link period; link clock stands still between frames
  always
  begin
    wait (busy_req === 1'b1);
    #80 sda_pull = 1'b1;
    repeat (2)
    begin
      #80 scl_pull = 1'b1;
      #80 scl_pull = 1'b0;
    end
    wait (busy_req === 1'b0);
    #80 sda_pull = 1'b0;
    #80;
  end

  // conditions seen on the wire: data edges while the clock line is high
  always @(negedge sda) if (scl === 1'b1) start_cnt++;
  always @(posedge sda) if (scl === 1'b1) stop_cnt++;
endmodule // i2cs_bus_peer

/* File: verif/i2c_master_start_stop_control_test.sv */
// i2c_master_start_stop_control_test: directed bench for the start/stop control block
// assumes a classic wishbone master here, pull-up wires, one peer model on the bus
`timescale 1ns/10ps
`include "i2cs_params.svh"

module i2c_master_start_stop_control_test;
  logic clk, reset_n, cyc, stb, we, byte_done, addr_match, busy_req;
  logic [4:0] adr;
  logic [31:0] dat_w, dat_r, q;
  logic irq_o, scl_o, scl_oe, sda_o, sda_oe, master_o, slv_o, ack;
  logic p_scl, p_sda;
  wire scl = (scl_oe ? scl_o : 1'b1) & ~p_scl;
  wire sda = (sda_oe ? sda_o : 1'b1) & ~p_sda;
  int starts, stops, mismatches, tests_run, n, s0, t0;

  i2cs_ctrl dut_u (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .irq_o(irq_o),
    .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .byte_done_i(byte_done), .addr_match_i(addr_match), .master_o(master_o), .slave_addressed_o(slv_o));
  i2cs_bus_peer peer_u (.scl(scl), .sda(sda), .busy_req(busy_req), .scl_pull(p_scl), .sda_pull(p_sda),
    .start_cnt(starts), .stop_cnt(stops));

  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task tmo;
    chk(32'h0, 32'h1);
    complete_run;
  endtask

  // one classic cycle; request held until ack is sampled high
  task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
      if (k > 50) tmo();
    end while (ack !== 1'b1);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return sda_oe;
      1: return scl_oe;
      2: return master_o;
      default: return sda;
    endcase
  endfunction

  // bounded wait on one observed signal, counting edges
  task wait_sig(input int k, input logic v, input int lim);
    n = 0;
    while (sig(k) !== v)
    begin
      @(posedge clk);
      n++;
      if (n > lim) tmo();
    end
  endtask

  task pulse(input int k);
    @(posedge clk);
    if (k == 0)
      byte_done <= 1'b1;
    else
      addr_match <= 1'b1;
    @(posedge clk);
    byte_done <= 1'b0;
    addr_match <= 1'b0;
  endtask

  task t_reset;
    wb(0, `I2CS_ADR_CTRL, 0);
    chk(q, 32'h0);
    wb(0, `I2CS_ADR_STAT, 0);
    chk(q, {24'h0, `I2CS_ST_IDLE});
    wb(1, 5'h14, 32'hFF);
    wb(0, 5'h14, 0);
    chk(q, 32'h0);
    $display("reset values done");
  endtask

  task t_gate;
    wb(1, `I2CS_ADR_CTRL, 32'h60);
    repeat (20) @(posedge clk);
    chk({sda_oe, scl_oe}, 2'h0);
    wb(1, `I2CS_ADR_CTRL, 32'h94);
    wb(0, `I2CS_ADR_CTRL, 0);
    chk(q, 32'h84);
    wb(1, `I2CS_ADR_CTRL, 32'h0);
    wb(1, `I2CS_ADR_HSEL, {30'h0, `I2CS_HSEL_ON});
    wb(1, `I2CS_ADR_IRQM, 32'h7);
    $display("enable gating done");
  endtask

  task t_stop(input logic [7:0] c);
    s0 = stops;
    wb(1, `I2CS_ADR_CTRL, {24'h0, c});
    wait_sig(2, 1'b0, 1000);
    repeat (2) @(posedge clk);
    wb(0, `I2CS_ADR_CTRL, 0);
    chk(q[4], 1'b0);
    chk(32'(stops - s0), 32'h1);
    wb(0, `I2CS_ADR_STAT, 0);
    chk(q, {24'h0, `I2CS_ST_IDLE});
    wb(0, `I2CS_ADR_IRQS, 0);
    chk(q[2], 1'b1);
    wb(1, `I2CS_ADR_IRQS, 32'h7);
  endtask

  task t_start(input logic [2:0] c, input logic [7:0] half);
    t0 = starts;
    wb(1, `I2CS_ADR_CTRL, {24'h0, c[2], 3'h6, 2'h0, c[1:0]});
    wait_sig(0, 1'b1, 10);
    wait_sig(1, 1'b1, 300);
    chk(32'(n), {24'h0, half} + 32'h1);
    repeat (2) @(posedge clk);
    chk(32'(starts - t0), 32'h1);
    wb(0, `I2CS_ADR_STAT, 0);
    chk(q, {24'h0, `I2CS_ST_START});
    wb(0, `I2CS_ADR_CTRL, 0);
    chk(q[3], 1'b1);
    chk({irq_o, master_o}, 2'h3);
    wb(1, `I2CS_ADR_IRQS, 32'h1);
    // enable kept, start request and interrupt flag cleared
    wb(1, `I2CS_ADR_CTRL, {24'h0, c[2], 5'h10, c[1:0]});
    @(posedge clk);
    chk(irq_o, 1'b0);
    pulse(0);
    repeat (3 * half) @(posedge clk);
    wb(0, `I2CS_ADR_STAT, 0);
    chk(q, {24'h0, `I2CS_ST_START});
    chk(32'(starts - t0), 32'h1);
    // enable and stop request set
    t_stop({c[2], 5'h14, c[1:0]});
    $display("start at rate %0d done", c);
  endtask

  task t_rstart;
    wb(1, `I2CS_ADR_CTRL, 32'h60);
    wait_sig(2, 1'b1, 300);
    t0 = starts;
    pulse(0);
    n = 0;
    do
    begin
      wb(0, `I2CS_ADR_STAT, 0);
      n++;
      if (n > 100) tmo();
    end while (q[7:0] === `I2CS_ST_START);
    chk(q, {24'h0, `I2CS_ST_RSTART});
    chk(32'(starts - t0), 32'h1);
    s0 = stops;
    wb(1, `I2CS_ADR_CTRL, 32'h70);
    wait_sig(2, 1'b0, 300);
    wait_sig(2, 1'b1, 300);
    chk(32'(stops - s0), 32'h1);
    chk(32'(starts - t0), 32'h2);
    wb(1, `I2CS_ADR_IRQS, 32'h7);
    t_stop(8'h50);
    $display("repeated start done");
  endtask

  task t_busy;
    busy_req <= 1'b1;
    wait_sig(3, 1'b0, 100);
    // the pin filter needs a few cycles before the foreign start marks the bus busy
    repeat (8) @(posedge clk);
    wb(1, `I2CS_ADR_CTRL, 32'h60);
    repeat (30) @(posedge clk);
    chk(sda_oe, 1'b0);
    busy_req <= 1'b0;
    wait_sig(3, 1'b1, 100);
    wait_sig(0, 1'b1, 100);
    chk({31'h0, n >= 6 && n <= 14}, 32'h1);
    wait_sig(2, 1'b1, 100);
    t_stop(8'h50);
    $display("deferred start done");
  endtask

  // slave error recovery, then start requested as addressed slave
  task t_slave;
    s0 = stops;
    pulse(1);
    // the addressed flag is launched at the edge pulse returns on; look one edge later
    @(posedge clk);
    chk(slv_o, 1'b1);
    wb(1, `I2CS_ADR_IRQM, 32'h0);
    wb(1, `I2CS_ADR_CTRL, 32'h50);
    repeat (2) @(posedge clk);
    chk({slv_o, sda_oe, scl_oe, irq_o}, 4'h0);
    wb(0, `I2CS_ADR_CTRL, 0);
    chk(q, 32'h40);
    wb(0, `I2CS_ADR_IRQS, 0);
    chk(q, 32'h4);
    wb(1, `I2CS_ADR_IRQM, 32'h7);
    @(posedge clk);
    chk(irq_o, 1'b1);
    wb(1, `I2CS_ADR_IRQS, 32'h4);
    pulse(1);
    wb(1, `I2CS_ADR_CTRL, 32'h70);
    wait_sig(2, 1'b1, 300);
    chk({slv_o, 31'(stops - s0)}, 32'h0);
    t_stop(8'h50);
    $display("slave recovery done");
  endtask

  initial
  begin
    reset_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 5'h00;
    dat_w = 32'h0;
    byte_done = 1'b0;
    addr_match = 1'b0;
    busy_req = 1'b0;
    mismatches = 0;
    tests_run = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_gate;
    t_start(3'h0, `I2CS_HALF_0);
    t_start(3'h5, `I2CS_HALF_5);
    t_rstart;
    t_busy;
    t_slave; // bus left with a stop request, never by clearing enable
    complete_run;
  end

  // hang guard
  initial
  begin
    repeat (100000) @(posedge clk);
    tmo();
  end
endmodule // i2c_master_start_stop_control_test
